// file: common/adcsp_pkg.sv
// constants and carrier types of the converter serial port block
// assumes one system clock domain; link pins arrive unsynchronised
package adcsp_pkg;
	localparam int CMD_BITS  = 8;
	localparam int CTRL_BITS = 16;
	localparam int DATA_BITS = 24;
	localparam int ADDR_BITS = 6;
	localparam int CNT_BITS  = 5;
	localparam int RW_POS    = 6;
	localparam int NREG      = 8;
	localparam int IDX_BITS  = 3;
	localparam logic [ADDR_BITS-1:0] ADDR_MODE = 6'h01;
	localparam logic [ADDR_BITS-1:0] ADDR_DATA = 6'h04;
	localparam logic [CTRL_BITS-1:0] CTRL_RST  = 16'h0000;
	localparam int CLKSEL_LSB = 2;
	localparam logic [1:0] CLKSEL_INT     = 2'h0;
	localparam logic [1:0] CLKSEL_INT_OUT = 2'h1;
	localparam logic [1:0] CLKSEL_EXT     = 2'h2;
	localparam logic [1:0] CLKSEL_XTAL    = 2'h3;
	localparam int CLKDIV_HALF = 2;
	localparam int FIFO_DEPTH  = 4;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic din;
		logic xclk;
	} adcsp_pins_t;

	typedef enum logic {PH_CMD, PH_DATA} adcsp_phase_t;
endpackage : adcsp_pkg

// file: verilog/adcsp_top.sv
// converter serial port: link slave, control registers, result fifo, clock pin
// assumes the host clocks the link far slower than I_MCLK (edges found by sampling)
`timescale 1ns/1ps

module adcsp_fifo
	import adcsp_pkg::*;
#(
	parameter int W     = DATA_BITS,
	parameter int DEPTH = FIFO_DEPTH
)(
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_in_data,
	input  wire logic         i_in_valid,
	output logic              o_in_ready,
	output logic [W-1:0]      o_out_data,
	output logic              o_out_valid,
	input  wire logic         i_out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0]           wr;
		logic [PW-1:0]           rd;
		logic [CW-1:0]           cnt;
	} adcsp_fifo_st_t;
	adcsp_fifo_st_t q, n;
	logic push, pop;

	assign o_in_ready  = (q.cnt != CW'(DEPTH));
	assign o_out_valid = (q.cnt != '0);
	assign o_out_data  = q.mem[q.rd];
	assign push        = i_ce & i_in_valid & o_in_ready;
	assign pop         = i_ce & o_out_valid & i_out_ready;

	always_comb
	begin
		n = q;
		if (push)
		begin
			n.mem[q.wr] = i_in_data;
			n.wr        = (q.wr == PW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
		end
		if (pop)
			n.rd = (q.rd == PW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
		n.cnt = q.cnt + CW'(push) - CW'(pop);
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			q <= '0;
		else if (i_ce)
			q <= n;
	end
endmodule : adcsp_fifo

module adcsp_top
	import adcsp_pkg::*;
(
	input  wire logic                 I_MCLK,
	input  wire logic                 I_RST,
	input  wire logic                 I_CE,
	input  wire logic                 I_SCLK,
	input  wire logic                 I_CS_N,
	input  wire logic                 I_DIN,
	output logic                      O_DOUT,
	output logic                      O_DOUT_OE_N,
	input  wire logic                 I_XTAL_CLK,
	output logic                      O_XTAL_CLK,
	output logic                      O_XTAL_CLK_OE_N,
	output logic                      O_CORE_CLK_REF,
	input  wire logic [DATA_BITS-1:0] I_RES_DATA,
	input  wire logic                 I_RES_VALID,
	output logic                      O_RES_READY
);
	typedef struct packed {
		adcsp_pins_t                  s1;
		adcsp_pins_t                  s2;
		adcsp_pins_t                  prev;
		adcsp_phase_t                 phase;
		logic [CNT_BITS-1:0]          cnt;
		logic [DATA_BITS-1:0]         sh_in;
		logic [DATA_BITS-1:0]         sh_out;
		logic                         rd;
		logic [ADDR_BITS-1:0]         addr;
		logic                         dout;
		logic                         rdy_n;
		logic [DATA_BITS-1:0]         data;
		logic [NREG-1:0][CTRL_BITS-1:0] regs;
		logic [1:0]                   div;
		logic                         clk_out;
	} adcsp_st_t;
	adcsp_st_t q, n;

	logic                 rise, fall, cs_n, reading, idle, upd, pop;
	logic                 f_valid;
	logic [DATA_BITS-1:0] f_data;
	logic [DATA_BITS-1:0] cmd_word;
	logic [1:0]           clk_sel;

	adcsp_fifo #(.W(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk       (I_MCLK),
		.i_rst       (I_RST),
		.i_ce        (I_CE),
		.i_in_data   (I_RES_DATA),
		.i_in_valid  (I_RES_VALID),
		.o_in_ready  (O_RES_READY),
		.o_out_data  (f_data),
		.o_out_valid (f_valid),
		.i_out_ready (pop)
	);

	// edges found on the second sync stage against its own delayed copy
	assign rise     = I_CE & q.s2.sclk & ~q.prev.sclk;
	assign fall     = I_CE & ~q.s2.sclk & q.prev.sclk;
	assign cs_n     = q.s2.cs_n;
	assign reading  = (q.phase == PH_DATA) & q.rd;
	// results only move while the link is between transactions
	assign idle     = cs_n | ((q.phase == PH_CMD) & (q.cnt == '0));
	assign upd      = I_CE & f_valid & idle;
	assign pop      = upd & q.rdy_n;
	assign cmd_word = {q.sh_in[DATA_BITS-2:0], q.s2.din};
	assign clk_sel  = q.regs[ADDR_MODE[IDX_BITS-1:0]][CLKSEL_LSB+1:CLKSEL_LSB];

	function automatic logic [DATA_BITS-1:0] rd_word(input adcsp_st_t s,
		input logic [ADDR_BITS-1:0] a);
		logic [DATA_BITS-1:0] w;
		w = '0;
		if (a == ADDR_DATA)
			w = s.data;
		else if (a < ADDR_BITS'(NREG))
			w = {s.regs[a[IDX_BITS-1:0]], (DATA_BITS-CTRL_BITS)'(0)};
		return w;
	endfunction : rd_word

	always_comb
	begin
		n      = q;
		n.s1   = '{sclk: I_SCLK, cs_n: I_CS_N, din: I_DIN, xclk: I_XTAL_CLK};
		n.s2   = q.s1;
		n.prev = q.s2;
		if (cs_n)
		begin
			n.phase = PH_CMD;
			n.cnt   = '0;
		end
		else if (rise)
		begin
			n.sh_in = cmd_word;
			n.cnt   = q.cnt + 1'b1;
			if (q.phase == PH_CMD && q.cnt == CNT_BITS'(CMD_BITS - 1))
			begin
				n.cnt   = '0;
				n.phase = PH_DATA;
				n.rd    = cmd_word[RW_POS];
				n.addr  = cmd_word[ADDR_BITS-1:0];
				if (cmd_word[RW_POS])
					n.sh_out = rd_word(q, cmd_word[ADDR_BITS-1:0]);
			end
			else if (q.phase == PH_DATA && q.cnt == ((q.addr == ADDR_DATA) ?
				CNT_BITS'(DATA_BITS - 1) : CNT_BITS'(CTRL_BITS - 1)))
			begin
				n.phase = PH_CMD;
				n.cnt   = '0;
				// the result register is read-only from the link
				if (!q.rd && q.addr != ADDR_DATA && q.addr < ADDR_BITS'(NREG))
					n.regs[q.addr[IDX_BITS-1:0]] = cmd_word[CTRL_BITS-1:0];
				if (q.rd && q.addr == ADDR_DATA)
					n.rdy_n = 1'b1;
			end
		end
		else if (fall && reading)
		begin
			n.dout   = q.sh_out[DATA_BITS-1];
			n.sh_out = {q.sh_out[DATA_BITS-2:0], 1'b0};
		end
		// unread result: flag goes high one cycle before the new one lands
		if (upd && !q.rdy_n)
			n.rdy_n = 1'b1;
		if (pop)
		begin
			n.data  = f_data;
			n.rdy_n = 1'b0;
		end
		n.div = q.div + 1'b1;
		if (q.div == 2'(CLKDIV_HALF - 1))
		begin
			n.div     = '0;
			n.clk_out = ~q.clk_out;
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			q       <= '0;
			q.s1    <= '1;
			q.s2    <= '1;
			q.prev  <= '1;
			q.rdy_n <= 1'b1;
			q.regs  <= {NREG{CTRL_RST}};
		end
		else if (I_CE)
			q <= n;
	end

	assign O_DOUT          = reading ? q.dout : q.rdy_n;
	assign O_DOUT_OE_N     = cs_n;
	assign O_XTAL_CLK      = q.clk_out;
	assign O_XTAL_CLK_OE_N = (clk_sel != CLKSEL_INT_OUT);
	assign O_CORE_CLK_REF  = (clk_sel == CLKSEL_EXT || clk_sel == CLKSEL_XTAL) ?
		q.s2.xclk : q.clk_out;

	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (I_RST);

	a_oe_cs_high: assert property (cs_n |-> O_DOUT_OE_N)
		else $error("output driven while deselected");
	a_dout_fall: assert property (fall && reading && !cs_n
		|=> O_DOUT == $past(q.sh_out[DATA_BITS-1]))
		else $error("output bit not taken on falling edge");
	a_dout_steady: assert property (reading && !fall && !rise && I_CE |=> $stable(q.dout))
		else $error("output bit moved without falling edge");
	a_rdy_flag: assert property (!cs_n && !reading |-> O_DOUT == q.rdy_n)
		else $error("ready flag not shown on output");
	a_rdy_load_low: assert property (pop |=> !q.rdy_n && q.data == $past(f_data))
		else $error("result load did not lower ready");
	a_rdy_high_first: assert property (upd && !q.rdy_n
		|=> q.rdy_n ##1 (q.rdy_n || $past(pop)))
		else $error("unread result replaced without ready high");
	a_din_rise: assert property (rise && !cs_n |=> q.sh_in[0] == $past(q.s2.din))
		else $error("input bit not sampled on rising edge");
	a_reg_write: assert property (rise && !cs_n && q.phase == PH_DATA && !q.rd
		&& q.addr == ADDR_MODE && q.cnt == CNT_BITS'(CTRL_BITS - 1)
		|=> q.regs[ADDR_MODE[IDX_BITS-1:0]] == $past(cmd_word[CTRL_BITS-1:0]))
		else $error("control write lost");
	a_read_load: assert property (rise && !cs_n && q.phase == PH_CMD
		&& q.cnt == CNT_BITS'(CMD_BITS - 1) && cmd_word[RW_POS]
		&& cmd_word[ADDR_BITS-1:0] == ADDR_DATA |=> q.sh_out == q.data)
		else $error("output shift register not loaded");
	a_clk_pin_dir: assert property (clk_sel == CLKSEL_INT_OUT |-> !O_XTAL_CLK_OE_N)
		else $error("clock pin not driven in output mode");

	c_data_read: cover property (rise && q.phase == PH_DATA && q.rd && q.addr == ADDR_DATA);
	c_ctrl_write: cover property (rise && q.phase == PH_DATA && !q.rd && q.addr == ADDR_MODE);
	c_unread_drop: cover property (upd && !q.rdy_n);
	c_fifo_full: cover property (!O_RES_READY);
endmodule : adcsp_top

// file: testbench/adcsp_host_model.sv
// host serial master model for the converter serial port
// assumes the system clock is fed in; link half period is 20 system cycles
`timescale 1ns/1ps

module adcsp_host (
	input  wire logic i_mclk,
	input  wire logic i_dout,
	input  wire logic i_dout_oe_n,
	output logic      o_sclk,
	output logic      o_cs_n,
	output logic      o_din,
	output logic      o_line
);
	logic last_q = 1'b0;

	initial
	begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_din  = 1'b0;
	end

	// released line has no pull, so show the inverse of the last level
	always @(posedge i_mclk)
		if (!i_dout_oe_n)
			last_q <= i_dout;
	assign o_line = i_dout_oe_n ? ~last_q : i_dout;

	task automatic xfer(input logic [7:0] cmd, input logic [23:0] wd, input int nd,
		output logic [23:0] rd);
		logic [31:0] sh;
		rd = '0;
		sh = {cmd, 24'h0} | (32'(wd) << (24 - nd));
		@(negedge i_mclk);
		o_cs_n = 1'b0;
		repeat (4) @(negedge i_mclk);
		for (int i = 0; i < 8 + nd; i++)
		begin
			o_sclk = 1'b0;
			o_din  = sh[31 - i];
			repeat (20) @(negedge i_mclk);
			rd = {rd[22:0], o_line};
			o_sclk = 1'b1;
			repeat (20) @(negedge i_mclk);
		end
	endtask : xfer

	task automatic deselect;
		@(negedge i_mclk);
		o_cs_n = 1'b1;
		repeat (8) @(negedge i_mclk);
	endtask : deselect
endmodule : adcsp_host

// file: testbench/tb.sv
// bench of the converter serial port driven by the host model
// assumes package and design compile first
`timescale 1ns/1ps

module tb;
	import adcsp_pkg::*;
	logic                 I_MCLK = 1'b0;
	logic                 I_RST = 1'b1;
	logic                 I_XTAL_CLK = 1'b0;
	logic                 I_CE = 1'b1;
	logic                 I_RES_VALID = 1'b0;
	logic [DATA_BITS-1:0] I_RES_DATA = '0;
	logic                 sclk, cs_n, din, dout, oe_n, line, xclk, xoe_n, cref, rdy;
	logic [23:0]          r;
	int                   bad_count = 0, total_checks = 0, cyc = 0, rises = 0;

	always #2 I_MCLK = ~I_MCLK;
	always @(posedge dout) rises++;

	adcsp_host host (.i_mclk(I_MCLK), .i_dout(dout), .i_dout_oe_n(oe_n), .o_sclk(sclk),
		.o_cs_n(cs_n), .o_din(din), .o_line(line));
	adcsp_top DUT (.I_MCLK(I_MCLK), .I_RST(I_RST), .I_CE(I_CE), .I_SCLK(sclk),
		.I_CS_N(cs_n), .I_DIN(din), .O_DOUT(dout), .O_DOUT_OE_N(oe_n),
		.I_XTAL_CLK(I_XTAL_CLK), .O_XTAL_CLK(xclk), .O_XTAL_CLK_OE_N(xoe_n),
		.O_CORE_CLK_REF(cref), .I_RES_DATA(I_RES_DATA), .I_RES_VALID(I_RES_VALID),
		.O_RES_READY(rdy));

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	always @(posedge I_MCLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			bad_count++;
			results();
		end
	end

	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		total_checks++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			bad_count++;
		end
	endtask : chk

	task automatic push(input logic [23:0] d, output logic ok);
		@(negedge I_MCLK);
		I_RES_DATA  = d;
		I_RES_VALID = 1'b1;
		ok = rdy;
		@(negedge I_MCLK);
		I_RES_VALID = 1'b0;
	endtask : push

	task automatic t_reset;
		logic ok;
		chk("dout enable", 1, oe_n);
		chk("ready flag", 1, dout);
		chk("clock pin enable", 1, xoe_n);
		chk("result ready", 1, rdy);
		// a result offered while frozen must not be taken
		I_CE = 1'b0;
		push(24'h0f0f0f, ok);
		repeat (8) @(negedge I_MCLK);
		chk("frozen ready flag", 1, dout);
		I_CE = 1'b1;
		repeat (8) @(negedge I_MCLK);
		chk("no result after freeze", 1, dout);
		$display("test reset done");
	endtask : t_reset

	task automatic t_mode;
		logic a;
		host.xfer(8'h01, 24'h0004, 16, r);
		repeat (8) @(negedge I_MCLK);
		chk("clock pin enable", 0, xoe_n);
		a = xclk;
		repeat (2) @(negedge I_MCLK);
		chk("clock out toggle", !a, xclk);
		chk("core clock internal", xclk, cref);
		host.xfer(8'h41, 0, 16, r);
		chk("mode readback", 24'h0004, r[15:0]);
		host.xfer(8'h49, 0, 16, r);
		chk("unmapped read", 0, r[15:0]);
		host.xfer(8'h01, 24'h0008, 16, r);
		I_XTAL_CLK = 1'b1;
		repeat (8) @(negedge I_MCLK);
		chk("clock pin release", 1, xoe_n);
		chk("external clock", 1, cref);
		repeat (2) @(negedge I_MCLK);
		chk("external clock", 1, cref);
		host.xfer(8'h01, 24'h000c, 16, r);
		I_XTAL_CLK = 1'b0;
		repeat (8) @(negedge I_MCLK);
		chk("crystal clock", 0, cref);
		repeat (2) @(negedge I_MCLK);
		chk("crystal clock", 0, cref);
		chk("crystal pin release", 1, xoe_n);
		$display("test mode done");
	endtask : t_mode

	task automatic t_result;
		logic ok;
		int   acc;
		acc = 0;
		push(24'h123456, ok);
		repeat (12) @(negedge I_MCLK);
		chk("ready low", 0, line);
		fork
			host.xfer(8'h44, 0, 24, r);
			begin
				// fifo is not drained mid transfer, so it must fill
				repeat (400) @(negedge I_MCLK);
				for (int i = 0; i < 6; i++)
				begin
					push(24'h5a0000 + 24'(i), ok);
					acc += int'(ok);
				end
			end
		join
		chk("result read", 24'h123456, r);
		chk("fifo accepted", 4, 24'(acc));
		repeat (40) @(negedge I_MCLK);
		chk("ready after drain", 0, line);
		rises = 0;
		push(24'hc3c3c3, ok);
		repeat (20) @(negedge I_MCLK);
		chk("ready pulses", 1, 24'(rises));
		chk("ready low again", 0, line);
		host.xfer(8'h44, 0, 24, r);
		chk("newest result", 24'hc3c3c3, r);
		host.deselect();
		chk("dout released", 1, oe_n);
		$display("test result done");
	endtask : t_result

	initial
	begin
		repeat (8) @(negedge I_MCLK);
		I_RST = 1'b0;
		repeat (3) @(negedge I_MCLK);
		t_reset();
		t_mode();
		t_result();
		results();
	end
endmodule : tb
